// ### design/tick_timer_pkg.sv
// Shared constants and types for the system tick timer
package tick_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_RELOAD   = 8'h04;
  localparam logic [7:0] OFF_CURRENT  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // Control and status field positions
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_IRQ_EN   = 1;
  localparam int BIT_CLK_SEL  = 2;
  localparam int BIT_ZERO_FLG = 16;

  // Interrupt status bit positions
  localparam int EVT_ZERO = 0;
  localparam int EVT_STOP = 1;
  localparam int N_EVT    = 2;

  // Widths and reset values
  localparam int          CNT_W       = 24;
  localparam logic [23:0] RELOAD_MAX  = 24'hFFFFFF;
  localparam logic [23:0] RELOAD_RST  = 24'h000000;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_CTRL     = 3'b001,
    SEL_RELOAD   = 3'b010,
    SEL_CURRENT  = 3'b011,
    SEL_IRQ_STAT = 3'b100,
    SEL_IRQ_MASK = 3'b101
  } reg_sel_t;

  typedef struct packed {
    logic clk_sel;
    logic irq_en;
    logic enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{clk_sel: 1'b0, irq_en: 1'b0, enable: 1'b0};

  typedef struct packed {
    logic stop;
    logic zero;
  } evt_t;

endpackage

// ### design/tick_down_counter.sv
// Down counter with wrap-value reload and zero-step pulses
`timescale 1ns/1ns
module tick_down_counter #(
  parameter int CNT_W = tick_timer_pkg::CNT_W
) (
  input  wire logic             ref_clk,   // Core clock
  input  wire logic             rst_n,     // Async reset, active low
  input  wire logic             run,       // Counter enable
  input  wire logic             irq_en,    // Pend tick on zero
  input  wire logic             halt,      // Core halted in debug
  input  wire logic             clear,     // Write to current value
  input  wire logic [CNT_W-1:0] reload,    // Wrap value
  output logic      [CNT_W-1:0] count,     // Current value
  output tick_timer_pkg::evt_t  evt,       // Registered event pulses
  output logic                  tick_pend  // Tick exception pulse
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             step_zero;
  logic             counting;

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("CNT_W out of range");
  end

  assign counting = run && !halt && !clear;

  always_comb begin
    cnt_nxt   = cnt_r;
    step_zero = 1'b0;
    if (clear) begin
      cnt_nxt = '0;
    end else if (counting) begin
      if (cnt_r == '0) begin
        if (reload != '0) begin
          cnt_nxt = reload;
        end
      end else begin
        cnt_nxt   = cnt_r - CNT_W'(1);
        step_zero = (cnt_r == CNT_W'(1));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= '0;
      evt       <= '0;
      tick_pend <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      evt.zero  <= step_zero;
      evt.stop  <= step_zero && (reload == '0);
      tick_pend <= step_zero && irq_en;
    end
  end

  assign count = cnt_r;
endmodule  // tick_down_counter

// ### design/sticky_irq.sv
// Sticky event status with mask and level interrupt
`timescale 1ns/1ns
module sticky_irq #(
  parameter int N = tick_timer_pkg::N_EVT
) (
  input  wire logic         ref_clk,  // Core clock
  input  wire logic         rst_n,    // Async reset, active low
  input  wire logic [N-1:0] set,      // Event pulses
  input  wire logic         rd_clr,   // Status read clears all
  input  wire logic         mask_we,  // Mask write
  input  wire logic [N-1:0] mask_d,   // Mask write data
  output logic      [N-1:0] status,   // Sticky status
  output logic      [N-1:0] mask,     // Enable mask
  output logic              irq       // Level interrupt
);
  logic [N-1:0] stat_nxt;

  initial begin
    if (N < 1 || N > 32) $error("N out of range");
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set wins over the read clear
      assign stat_nxt[i] = set[i] | (status[i] & ~rd_clr);
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          status[i] <= 1'b0;
        end else begin
          status[i] <= stat_nxt[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= N'(tick_timer_pkg::IRQ_MASK_RST);
      irq  <= 1'b0;
    end else begin
      if (mask_we) begin
        mask <= mask_d;
      end
      irq <= |(stat_nxt & (mask_we ? mask_d : mask));
    end
  end
endmodule  // sticky_irq

// ### design/system_tick_timer.sv
// System tick timer top with AXI4-Lite register slave
//
// Behaviour
// - 24-bit decrementing counter, wraps on zero, cleared by any current-value write.
// - When enabled, count to zero, load wrap value next edge, continue down.
// - A zero wrap value stops the counter at the next wrap.
// - Zero-reached flag sets whenever the counter reaches zero.
// - Reading control and status returns the zero-reached flag, then clears it.
// - Any write to current value clears counter and zero-reached flag.
// - Clearing through the current-value write never pends the tick exception.
// - Current-value read returns the count sampled at the access.
// - Counter holds while the core is halted in debug.
// - Reference is selectable, core clock or external, by the clock select.
// - Control/status register plus separate wrap-value and current-value registers.
// - No calibration register is implemented.
// - Tick interrupt enable at bit 1 pends the tick exception on zero.
// - Clock select at bit 2; external not built, so core clock always.
// - Wrap value in bits 23:0, period is value plus one clocks.
// - Enable at bit 0, zero-reached flag at bit 16; enable 0 stops.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module system_tick_timer #(
  parameter int CNT_W  = tick_timer_pkg::CNT_W,
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,        // Core clock, 10 MHz
  input  wire logic              rst_n,          // Async reset, active low
  input  wire logic              debug_halted,   // Core halted in debug
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // Write address
  input  wire logic              s_axi_awvalid,  // Write address valid
  output logic                   s_axi_awready,  // Write address ready
  input  wire logic [31:0]       s_axi_wdata,    // Write data
  input  wire logic [3:0]        s_axi_wstrb,    // Write byte strobes
  input  wire logic              s_axi_wvalid,   // Write data valid
  output logic                   s_axi_wready,   // Write data ready
  output logic [1:0]             s_axi_bresp,    // Write response
  output logic                   s_axi_bvalid,   // Write response valid
  input  wire logic              s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // Read address
  input  wire logic              s_axi_arvalid,  // Read address valid
  output logic                   s_axi_arready,  // Read address ready
  output logic [31:0]            s_axi_rdata,    // Read data
  output logic [1:0]             s_axi_rresp,    // Read response
  output logic                   s_axi_rvalid,   // Read data valid
  input  wire logic              s_axi_rready,   // Read data ready
  output logic                   tick_pend,      // Tick exception pulse
  output logic                   irq             // Masked status interrupt
);

  initial begin
    if (CNT_W < 2 || CNT_W > tick_timer_pkg::CNT_W) $error("CNT_W out of range");
    if (ADDR_W < 5 || ADDR_W > 32) $error("ADDR_W out of range");
  end

  // Word decode shared by read and write paths
  function automatic tick_timer_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [7:0] off;
    off = 8'(a) & 8'hFC;
    if (a[ADDR_W-1:2] != (ADDR_W-2)'(off[7:2])) begin
      decode = tick_timer_pkg::SEL_NONE;
    end else begin
      case (off)
        tick_timer_pkg::OFF_CTRL:     decode = tick_timer_pkg::SEL_CTRL;
        tick_timer_pkg::OFF_RELOAD:   decode = tick_timer_pkg::SEL_RELOAD;
        tick_timer_pkg::OFF_CURRENT:  decode = tick_timer_pkg::SEL_CURRENT;
        tick_timer_pkg::OFF_IRQ_STAT: decode = tick_timer_pkg::SEL_IRQ_STAT;
        tick_timer_pkg::OFF_IRQ_MASK: decode = tick_timer_pkg::SEL_IRQ_MASK;
        default:                      decode = tick_timer_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge of write data onto an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // ---------------- Write channel ----------------
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_got_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_got_r;
  wire               aw_hs = s_axi_awvalid && s_axi_awready;
  wire               w_hs  = s_axi_wvalid && s_axi_wready;
  wire               b_hs  = s_axi_bvalid && s_axi_bready;
  wire               wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  tick_timer_pkg::reg_sel_t wr_sel;
  assign wr_sel = decode(aw_addr_r);

  wire we_ctrl    = wr_go && (wr_sel == tick_timer_pkg::SEL_CTRL);
  wire we_reload  = wr_go && (wr_sel == tick_timer_pkg::SEL_RELOAD);
  wire we_current = wr_go && (wr_sel == tick_timer_pkg::SEL_CURRENT);
  wire we_mask    = wr_go && (wr_sel == tick_timer_pkg::SEL_IRQ_MASK);
  wire wr_bad     = (wr_sel == tick_timer_pkg::SEL_NONE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr_r     <= '0;
      aw_got_r      <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_addr_r <= s_axi_awaddr;
      end
      aw_got_r      <= aw_hs || (aw_got_r && !wr_go);
      s_axi_awready <= !aw_hs && !aw_got_r && (!s_axi_bvalid || b_hs);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_data_r     <= '0;
      w_strb_r     <= '0;
      w_got_r      <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (w_hs) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      w_got_r      <= w_hs || (w_got_r && !wr_go);
      s_axi_wready <= !w_hs && !w_got_r && (!s_axi_bvalid || b_hs);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tick_timer_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_bad ? tick_timer_pkg::RESP_SLVERR : tick_timer_pkg::RESP_OKAY;
      end else if (b_hs) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- Control, wrap value ----------------
  tick_timer_pkg::ctrl_t ctrl_r;
  logic [CNT_W-1:0]      reload_r;
  logic                  zero_flag_r;
  wire  [31:0]           ctrl_word;
  wire  [31:0]           ctrl_new   = merge(ctrl_word, w_data_r, w_strb_r);
  wire  [31:0]           reload_new = merge(32'(reload_r), w_data_r, w_strb_r);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= tick_timer_pkg::CTRL_RST;
      reload_r <= CNT_W'(tick_timer_pkg::RELOAD_RST);
    end else begin
      if (we_ctrl) begin
        ctrl_r.enable  <= ctrl_new[tick_timer_pkg::BIT_ENABLE];
        ctrl_r.irq_en  <= ctrl_new[tick_timer_pkg::BIT_IRQ_EN];
        ctrl_r.clk_sel <= ctrl_new[tick_timer_pkg::BIT_CLK_SEL];
      end
      if (we_reload) begin
        reload_r <= reload_new[CNT_W-1:0];
      end
    end
  end

  // ---------------- Read channel ----------------
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire r_hs  = s_axi_rvalid && s_axi_rready;

  tick_timer_pkg::reg_sel_t rd_sel;
  assign rd_sel = decode(s_axi_araddr);

  wire rd_ctrl = ar_hs && (rd_sel == tick_timer_pkg::SEL_CTRL);
  wire rd_stat = ar_hs && (rd_sel == tick_timer_pkg::SEL_IRQ_STAT);

  // ---------------- Counter and events ----------------
  logic [CNT_W-1:0]     count;
  tick_timer_pkg::evt_t evt;
  logic [1:0]           irq_status;
  logic [1:0]           irq_mask;

  // External reference is absent, so either select runs on the core clock
  tick_down_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .run       (ctrl_r.enable),
    .irq_en    (ctrl_r.irq_en),
    .halt      (debug_halted),
    .clear     (we_current),
    .reload    (reload_r),
    .count     (count),
    .evt       (evt),
    .tick_pend (tick_pend)
  );

  // Flag set wins over the read and the current-value clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag_r <= 1'b0;
    end else if (evt.zero) begin
      zero_flag_r <= 1'b1;
    end else if (rd_ctrl || we_current) begin
      zero_flag_r <= 1'b0;
    end
  end

  sticky_irq #(
    .N (tick_timer_pkg::N_EVT)
  ) u_irq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .set     ({evt.stop, evt.zero}),
    .rd_clr  (rd_stat),
    .mask_we (we_mask),
    .mask_d  (w_data_r[1:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (irq)
  );

  // ---------------- Read data ----------------
  assign ctrl_word = (32'(zero_flag_r) << tick_timer_pkg::BIT_ZERO_FLG)
                   | (32'(ctrl_r.clk_sel) << tick_timer_pkg::BIT_CLK_SEL)
                   | (32'(ctrl_r.irq_en) << tick_timer_pkg::BIT_IRQ_EN)
                   | (32'(ctrl_r.enable) << tick_timer_pkg::BIT_ENABLE);

  logic [31:0] rd_word;
  always_comb begin
    case (rd_sel)
      tick_timer_pkg::SEL_CTRL:     rd_word = ctrl_word;
      tick_timer_pkg::SEL_RELOAD:   rd_word = 32'(reload_r);
      tick_timer_pkg::SEL_CURRENT:  rd_word = 32'(count);
      tick_timer_pkg::SEL_IRQ_STAT: rd_word = 32'(irq_status);
      tick_timer_pkg::SEL_IRQ_MASK: rd_word = 32'(irq_mask);
      default:                      rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= tick_timer_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !ar_hs && (!s_axi_rvalid || r_hs);
      if (ar_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_sel == tick_timer_pkg::SEL_NONE) ?
                        tick_timer_pkg::RESP_SLVERR : tick_timer_pkg::RESP_OKAY;
      end else if (r_hs) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule  // system_tick_timer

// ### bench/tick_timer_props.sv
// Concurrent checks on the tick timer top ports
`timescale 1ns/1ns
module tick_timer_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              ref_clk,       // Core clock
  input wire logic              rst_n,         // Reset, active low
  input wire logic              debug_halted,  // Debug halt
  input wire logic [ADDR_W-1:0] s_axi_awaddr,  // AW address
  input wire logic              s_axi_awvalid, // AW valid
  input wire logic              s_axi_awready, // AW ready
  input wire logic              s_axi_wvalid,  // W valid
  input wire logic              s_axi_wready,  // W ready
  input wire logic [1:0]        s_axi_bresp,   // B response
  input wire logic              s_axi_bvalid,  // B valid
  input wire logic              s_axi_bready,  // B ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // AR address
  input wire logic              s_axi_arvalid, // AR valid
  input wire logic              s_axi_arready, // AR ready
  input wire logic [31:0]       s_axi_rdata,   // R data
  input wire logic [1:0]        s_axi_rresp,   // R response
  input wire logic              s_axi_rvalid,  // R valid
  input wire logic              s_axi_rready,  // R ready
  input wire logic              tick_pend      // Tick request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_pend_pulse;
    tick_pend |=> !tick_pend;
  endproperty
  a_pend_pulse: assert property (p_pend_pulse) else $error("tick request too long");
  property p_halt_quiet;
    debug_halted ##1 debug_halted |=> !tick_pend;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("tick request while halted");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_wr_lat;
    s_wr_take |-> ##[2:3] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_cal_rd;
    s_rd_take and s_axi_araddr == 8'h0C |=>
      s_axi_rresp == tick_timer_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  a_cal_rd: assert property (p_cal_rd) else $error("absent register answered read");
  property p_cal_wr;
    s_wr_take and s_axi_awaddr == 8'h0C |->
      ##[2:3] (s_axi_bvalid && s_axi_bresp == tick_timer_pkg::RESP_SLVERR);
  endproperty
  a_cal_wr: assert property (p_cal_wr) else $error("absent register took write");
endmodule // tick_timer_props
bind system_tick_timer tick_timer_props #(.ADDR_W(ADDR_W)) i_tick_timer_props (.*);

// ### bench/tick_irq_ctrl_model.sv
// Interrupt controller stand-in that counts tick exception requests
`timescale 1ns/1ns
module tick_irq_ctrl_model (
  input  wire logic        ref_clk,   // Core clock
  input  wire logic        rst_n,     // Reset, active low
  input  wire logic        tick_pend, // Tick request
  output logic      [15:0] pend_cnt   // Requests taken
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pend_cnt <= 16'h0000;
    else if (tick_pend) pend_cnt <= pend_cnt + 16'h0001;
  end
endmodule // tick_irq_ctrl_model

// ### bench/system_tick_timer_tb.sv
// Self-checking bench for the system tick timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module system_tick_timer_tb;
  localparam logic [7:0] CTL = tick_timer_pkg::OFF_CTRL;
  localparam logic [7:0] RLD = tick_timer_pkg::OFF_RELOAD;
  localparam logic [7:0] CUR = tick_timer_pkg::OFF_CURRENT;
  localparam logic [7:0] STA = tick_timer_pkg::OFF_IRQ_STAT;
  localparam logic [7:0] MSK = tick_timer_pkg::OFF_IRQ_MASK;
  localparam logic [7:0] OFFS [5] = '{CTL, RLD, CUR, STA, MSK};
  logic        ref_clk, rst_n, debug_halted, tick_pend, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, hold;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] pend_cnt, snap;
  int          error_cnt, num_checks, gap, n;
  system_tick_timer i_system_tick_timer (.*);
  tick_irq_ctrl_model i_tick_irq_ctrl_model (.ref_clk, .rst_n, .tick_pend, .pend_cnt);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hung();
    if (n >= 500) begin
      error_cnt++;
      $display("Error bus wait expected answer seen none");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 500);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    hung();
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge ref_clk);
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 500);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    hung();
  endtask
  task automatic wait_pend();
    gap = 0;
    do begin
      @(posedge ref_clk);
      gap++;
    end while (!tick_pend && gap < 100);
    if (gap >= 100) begin
      error_cnt++;
      $display("Error tick wait expected pulse seen none");
      wrap_up();
    end
  endtask
  initial begin
    rst_n = 1'b0;
    debug_halted = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (OFFS[i]) begin
      rdt(OFFS[i]);
      `CHK("reset_value", 32'h00000000, rd)
    end
    rdt(8'h0C);
    `CHK("cal_rd_resp", tick_timer_pkg::RESP_SLVERR, rsp)
    `CHK("cal_rd_data", 32'h00000000, rd)
    wr(8'h0C, 32'hFFFFFFFF);
    `CHK("cal_wr_resp", tick_timer_pkg::RESP_SLVERR, rsp)
    $display("Test registers done");
    wr(RLD, 32'h00000005);
    wr(MSK, 32'h00000001);
    wr(CTL, 32'h00000007);
    rdt(CTL);
    `CHK("ctrl_back", 32'h00000007, rd & 32'h00000007)
    wait_pend();
    wait_pend();
    `CHK("period", 6, gap)
    `CHK("irq_on", 1'b1, irq)
    rdt(CUR);
    `CHK("cur_range", 1'b1, rd <= 32'h00000005)
    $display("Test periodic done");
    debug_halted <= 1'b1;
    rdt(CUR);
    hold = rd;
    snap = pend_cnt;
    repeat (20) @(posedge ref_clk);
    rdt(CUR);
    `CHK("halt_cur", hold, rd)
    `CHK("halt_pend", snap, pend_cnt)
    debug_halted <= 1'b0;
    $display("Test halt done");
    wr(RLD, 32'h00001000);
    repeat (10) @(posedge ref_clk);
    snap = pend_cnt;
    wr(CUR, 32'h000000A5);
    rdt(CTL);
    `CHK("flag_wclr", 1'b0, rd[16])
    rdt(CUR);
    `CHK("cur_reload", 1'b1, rd > 32'h00000FF0 && rd <= 32'h00001000)
    `CHK("wclr_pend", snap, pend_cnt)
    $display("Test clear done");
    wr(CTL, 32'h00000001);
    wr(MSK, 32'h00000000);
    wr(RLD, 32'h00000003);
    wr(CUR, 32'h00000000);
    snap = pend_cnt;
    repeat (20) @(posedge ref_clk);
    `CHK("no_pend", snap, pend_cnt)
    `CHK("irq_masked", 1'b0, irq)
    rdt(CTL);
    `CHK("flag_set", 1'b1, rd[16])
    $display("Test no interrupt done");
    wr(RLD, 32'h00000000);
    repeat (10) @(posedge ref_clk);
    rdt(CUR);
    `CHK("stopped", 32'h00000000, rd)
    wr(MSK, 32'h00000003);
    `CHK("irq_unmask", 1'b1, irq)
    rdt(STA);
    `CHK("stat_bits", 2'h3, rd[1:0])
    repeat (2) @(posedge ref_clk);
    `CHK("irq_clear", 1'b0, irq)
    rdt(CTL);
    `CHK("flag_first", 1'b1, rd[16])
    rdt(CTL);
    `CHK("flag_rclr", 1'b0, rd[16])
    $display("Test stop done");
    wrap_up();
  end
endmodule // system_tick_timer_tb
